// >>> rtl/cpu_register_and_flags.sv
// Programmer-visible CPU registers, program counter and condition flags
`timescale 1ns/10ps
`include "cpu_regs_cfg.svh"

module cpu_register_and_flags (
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Read ports
	input wire logic [2:0] rd_a_sel_i,
	input wire logic rd_a_high_i,
	input wire logic [2:0] rd_b_sel_i,
	input wire logic rd_b_high_i,
	input wire logic [2:0] addr_sel_i,
	output logic [15:0] rd_a_word_o,
	output logic [7:0] rd_a_byte_o,
	output logic [15:0] rd_b_word_o,
	output logic [7:0] rd_b_byte_o,
	output logic [15:0] addr_word_o,
	// Write port
	input wire logic wr_en_i,
	input wire logic wr_word_i,
	input wire logic wr_high_i,
	input wire logic [2:0] wr_sel_i,
	input wire logic [15:0] wr_data_i,
	// Stack pointer adjust
	input wire logic sp_inc_i,
	input wire logic sp_dec_i,
	output logic [15:0] stack_ptr_o,
	// Program counter
	input wire logic pc_load_i,
	input wire logic [15:0] pc_data_i,
	input wire logic pc_step_i,
	output logic [15:0] pc_o,
	// Reset vector fetch
	output logic vec_req_o,
	input wire logic vec_ack_i,
	input wire logic [15:0] vec_data_i,
	// Arithmetic flag update
	input wire logic [7:0] flag_upd_en_i,
	input wire cpu_regs_pkg::alu_op_type alu_op_i,
	input wire logic alu_word_i,
	input wire logic [15:0] alu_a_i,
	input wire logic [15:0] alu_b_i,
	input wire logic [15:0] alu_res_i,
	input wire logic shift_carry_i,
	input wire logic bit_carry_i,
	input wire logic use_bit_carry_i,
	input wire logic use_shift_carry_i,
	input wire logic exc_entry_i,
	// Flag register instructions
	input wire cpu_regs_pkg::flag_cmd_type flag_cmd_i,
	input wire logic [7:0] flag_data_i,
	input wire logic flag_restore_i,
	input wire logic [15:0] flag_stack_word_i,
	output logic [7:0] flags_o,
	output logic [15:0] flag_push_word_o,
	output logic [3:0] branch_cond_o,
	output logic irq_masked_o,
	// Decimal adjust
	input wire logic dec_sub_i,
	input wire logic [7:0] dec_in_i,
	output logic [7:0] dec_out_o,
	output logic dec_carry_o,
	// Bit select
	input wire logic [7:0] bit_operand_i,
	input wire logic [2:0] bit_num_i,
	output logic bit_value_o
);

	// ---------------------------------------------
	// State
	// ---------------------------------------------
	typedef struct packed {
		logic [7:0][15:0] gen;
		logic [15:0] pc;
		logic [7:0] flags;
		cpu_regs_pkg::run_state_type st;
		logic [15:0] a_word;
		logic [7:0] a_byte;
		logic [15:0] b_word;
		logic [7:0] b_byte;
		logic [15:0] addr;
		logic [7:0] dec;
		logic dec_c;
		logic bitv;
	} state_type;

	state_type s_q;
	state_type s_d;
	logic rst_sync1_q;
	logic rst_sync2_q;

	// ---------------------------------------------
	// Reset release
	// ---------------------------------------------
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_sync1_q <= 1'b0;
			rst_sync2_q <= 1'b0;
		end else begin
			rst_sync1_q <= 1'b1;
			rst_sync2_q <= rst_sync1_q;
		end
	end

	// ---------------------------------------------
	// Next state
	// ---------------------------------------------
	logic [4:0] nib_sum;
	logic [12:0] w_sum;
	logic [16:0] full_sum;
	logic carry_in;
	logic sub_op;
	logic msb_a;
	logic msb_b;
	logic msb_r;
	logic [7:0] nf;
	logic [7:0] adj;
	logic [8:0] dsum;

	always_comb begin
		s_d = s_q;
		nib_sum = 5'h00;
		w_sum = 13'h0000;
		full_sum = 17'h00000;
		nf = s_q.flags;
		adj = 8'h00;
		dsum = 9'h000;
		carry_in = (alu_op_i == cpu_regs_pkg::alu_addc || alu_op_i == cpu_regs_pkg::alu_subc)
			&& s_q.flags[`FLAG_CARRY_BIT];
		sub_op = (alu_op_i == cpu_regs_pkg::alu_sub) || (alu_op_i == cpu_regs_pkg::alu_subc)
			|| (alu_op_i == cpu_regs_pkg::alu_cmp) || (alu_op_i == cpu_regs_pkg::alu_neg);

		// Read ports are full-word pairs or one selected half
		s_d.a_word = s_q.gen[rd_a_sel_i];
		s_d.a_byte = rd_a_high_i ? s_q.gen[rd_a_sel_i][15:8] : s_q.gen[rd_a_sel_i][7:0];
		s_d.b_word = s_q.gen[rd_b_sel_i];
		s_d.b_byte = rd_b_high_i ? s_q.gen[rd_b_sel_i][15:8] : s_q.gen[rd_b_sel_i][7:0];
		// Address operand always whole word, spanning 64 kbytes
		s_d.addr = s_q.gen[addr_sel_i];

		// Writes: a byte write keeps the other half
		if (wr_en_i) begin
			if (wr_word_i) begin
				s_d.gen[wr_sel_i] = wr_data_i;
			end else if (wr_high_i) begin
				s_d.gen[wr_sel_i][15:8] = wr_data_i[7:0];
			end else begin
				s_d.gen[wr_sel_i][7:0] = wr_data_i[7:0];
			end
		end
		// Stack moves a whole word, only word steps
		if (sp_dec_i && !(wr_en_i && wr_sel_i == `STACK_REG_INDEX)) begin
			s_d.gen[`STACK_REG_INDEX] = s_q.gen[`STACK_REG_INDEX] - 16'h0002;
		end else if (sp_inc_i && !(wr_en_i && wr_sel_i == `STACK_REG_INDEX)) begin
			s_d.gen[`STACK_REG_INDEX] = s_q.gen[`STACK_REG_INDEX] + 16'h0002;
		end

		// Arithmetic flag values
		if (alu_word_i) begin
			w_sum = {1'b0, alu_a_i[11:0]} + {1'b0, (sub_op ? ~alu_b_i[11:0] : alu_b_i[11:0])}
				+ {12'h000, sub_op};
			full_sum = {1'b0, alu_a_i} + {1'b0, (sub_op ? ~alu_b_i : alu_b_i)}
				+ {16'h0000, sub_op};
			msb_a = alu_a_i[15];
			msb_b = alu_b_i[15];
			msb_r = alu_res_i[15];
			nf[`FLAG_HALF_BIT] = sub_op ? ~w_sum[12] : w_sum[12];
			nf[`FLAG_CARRY_BIT] = sub_op ? ~full_sum[16] : full_sum[16];
			nf[`FLAG_ZERO_BIT] = (alu_res_i == 16'h0000);
		end else begin
			nib_sum = {1'b0, alu_a_i[3:0]} + {1'b0, (sub_op ? ~alu_b_i[3:0] : alu_b_i[3:0])}
				+ {4'h0, sub_op ^ carry_in};
			full_sum = {9'h000, alu_a_i[7:0]} + {9'h000, (sub_op ? ~alu_b_i[7:0] : alu_b_i[7:0])}
				+ {16'h0000, sub_op ^ carry_in};
			msb_a = alu_a_i[7];
			msb_b = alu_b_i[7];
			msb_r = alu_res_i[7];
			nf[`FLAG_HALF_BIT] = sub_op ? ~nib_sum[4] : nib_sum[4];
			nf[`FLAG_CARRY_BIT] = sub_op ? ~full_sum[8] : full_sum[8];
			nf[`FLAG_ZERO_BIT] = (alu_res_i[7:0] == 8'h00);
		end
		nf[`FLAG_NEG_BIT] = msb_r;
		nf[`FLAG_OVF_BIT] = sub_op ? (msb_a != msb_b) && (msb_r != msb_a)
			: (msb_a == msb_b) && (msb_r != msb_a);
		if (alu_op_i == cpu_regs_pkg::alu_logic) begin
			nf[`FLAG_OVF_BIT] = 1'b0;
		end
		// Carry from shifter or bit accumulator
		if (use_shift_carry_i) begin
			nf[`FLAG_CARRY_BIT] = shift_carry_i;
		end else if (use_bit_carry_i) begin
			nf[`FLAG_CARRY_BIT] = bit_carry_i;
		end
		// User bits and mask bit never change from arithmetic updates
		nf[`FLAG_USER6_BIT] = s_q.flags[`FLAG_USER6_BIT];
		nf[`FLAG_USER4_BIT] = s_q.flags[`FLAG_USER4_BIT];
		nf[`FLAG_MASK_BIT] = s_q.flags[`FLAG_MASK_BIT];
		for (int i = 0; i < 8; i++) begin
			s_d.flags[i] = flag_upd_en_i[i] ? nf[i] : s_q.flags[i];
		end

		// Software flag instructions override hardware updates
		case (flag_cmd_i)
			cpu_regs_pkg::flag_load: begin
				s_d.flags = flag_data_i;
			end
			cpu_regs_pkg::flag_and: begin
				s_d.flags = s_q.flags & flag_data_i;
			end
			cpu_regs_pkg::flag_or: begin
				s_d.flags = s_q.flags | flag_data_i;
			end
			cpu_regs_pkg::flag_xor: begin
				s_d.flags = s_q.flags ^ flag_data_i;
			end
			default: begin
			end
		endcase
		// Restore takes the high byte only
		if (flag_restore_i) begin
			s_d.flags = flag_stack_word_i[15:8];
		end
		// Exception entry wins and masks interrupts
		if (exc_entry_i) begin
			s_d.flags[`FLAG_MASK_BIT] = 1'b1;
		end

		// Program counter, bit zero forced low
		if (pc_load_i) begin
			s_d.pc = {pc_data_i[15:1], 1'b0};
		end else if (pc_step_i) begin
			s_d.pc = s_q.pc + 16'h0002;
		end

		// Reset vector fetch
		case (s_q.st)
			cpu_regs_pkg::st_vec_req: begin
				if (vec_ack_i) begin
					s_d.pc = {vec_data_i[15:1], 1'b0};
					s_d.st = cpu_regs_pkg::st_run;
				end
			end
			default: begin
			end
		endcase

		// Decimal adjust on packed BCD using half-carry
		if (dec_sub_i) begin
			// Subtracting 6 per digit is adding its complement, borrow runs up the byte
			if (s_q.flags[`FLAG_HALF_BIT]) begin
				adj[3:0] = 4'hA;
				adj[7:4] = s_q.flags[`FLAG_CARRY_BIT] ? 4'h9 : 4'hF;
			end else if (s_q.flags[`FLAG_CARRY_BIT]) begin
				adj[7:4] = 4'hA;
			end
			dsum = {1'b0, dec_in_i} + {1'b0, adj};
			s_d.dec = dsum[7:0];
			s_d.dec_c = s_q.flags[`FLAG_CARRY_BIT];
		end else begin
			if (s_q.flags[`FLAG_HALF_BIT] || dec_in_i[3:0] > 4'h9) begin
				adj[3:0] = 4'h6;
			end
			if (s_q.flags[`FLAG_CARRY_BIT] || dec_in_i > 8'h99) begin
				adj[7:4] = 4'h6;
			end
			dsum = {1'b0, dec_in_i} + {1'b0, adj};
			s_d.dec = dsum[7:0];
			s_d.dec_c = dsum[8] || s_q.flags[`FLAG_CARRY_BIT] || (adj[7:4] == 4'h6);
		end
		s_d.bitv = bit_operand_i[bit_num_i];
	end

	// ---------------------------------------------
	// Registers
	// ---------------------------------------------
	always_ff @(posedge clk_i or negedge rst_sync2_q) begin
		if (!rst_sync2_q) begin
			// General registers stay unknown to software; zero here only for clean sim
			s_q <= '0;
			s_q.pc <= `RESET_VECTOR_ADDR;
			s_q.flags <= `FLAGS_RESET;
			s_q.st <= cpu_regs_pkg::st_vec_req;
		end else begin
			s_q <= s_d;
		end
	end

	// ---------------------------------------------
	// Outputs
	// ---------------------------------------------
	assign rd_a_word_o = s_q.a_word;
	assign rd_a_byte_o = s_q.a_byte;
	assign rd_b_word_o = s_q.b_word;
	assign rd_b_byte_o = s_q.b_byte;
	assign addr_word_o = s_q.addr;
	assign stack_ptr_o = s_q.gen[`STACK_REG_INDEX];
	assign pc_o = s_q.pc;
	assign vec_req_o = (s_q.st == cpu_regs_pkg::st_vec_req);
	assign flags_o = s_q.flags;
	assign flag_push_word_o = {s_q.flags, s_q.flags};
	assign branch_cond_o = s_q.flags[3:0];
	assign irq_masked_o = s_q.flags[`FLAG_MASK_BIT];
	assign dec_out_o = s_q.dec;
	assign dec_carry_o = s_q.dec_c;
	assign bit_value_o = s_q.bitv;

endmodule

// >>> rtl/cpu_regs_cfg.svh
// Constants for the CPU register file and condition flags
`ifndef CPU_REGS_CFG_SVH
`define CPU_REGS_CFG_SVH
`define FLAG_MASK_BIT 3'h7
`define FLAG_USER6_BIT 3'h6
`define FLAG_HALF_BIT 3'h5
`define FLAG_USER4_BIT 3'h4
`define FLAG_NEG_BIT 3'h3
`define FLAG_ZERO_BIT 3'h2
`define FLAG_OVF_BIT 3'h1
`define FLAG_CARRY_BIT 3'h0
`define RESET_VECTOR_ADDR 16'h0000
`define FLAGS_RESET 8'h80
`define STACK_REG_INDEX 3'h7
`endif

// >>> rtl/cpu_regs_pkg.sv
// Types shared by the CPU register file
package cpu_regs_pkg;
	typedef enum logic [2:0] {
		alu_none_type_op,
		alu_add,
		alu_addc,
		alu_sub,
		alu_subc,
		alu_cmp,
		alu_neg,
		alu_logic
	} alu_op_type;

	typedef enum logic [2:0] {
		flag_idle,
		flag_load,
		flag_and,
		flag_or,
		flag_xor
	} flag_cmd_type;

	typedef enum {
		st_vec_req,
		st_run
	} run_state_type;
endpackage

// >>> test/cpu_register_and_flags_asserts.sv
// Port checks for the register file and flags
`timescale 1ns/10ps
module cpu_register_and_flags_asserts (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic pc_load_i,
	input wire logic pc_step_i,
	input wire logic [15:0] pc_o,
	input wire logic vec_req_o,
	input wire logic vec_ack_i,
	input wire logic [15:0] vec_data_i,
	input wire logic exc_entry_i,
	input wire logic flag_restore_i,
	input wire logic [15:0] flag_stack_word_i,
	input wire logic [7:0] flags_o,
	input wire logic [15:0] flag_push_word_o,
	input wire logic [3:0] branch_cond_o,
	input wire logic irq_masked_o
);
	// ----------
	// Properties
	// ----------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	property p_push; flag_push_word_o == {flags_o, flags_o}; endproperty
	a_push: assert property (p_push) else $error("push word");
	property p_cond; branch_cond_o == flags_o[3:0]; endproperty
	a_cond: assert property (p_cond) else $error("branch conditions");
	property p_mask; irq_masked_o == flags_o[7]; endproperty
	a_mask: assert property (p_mask) else $error("mask output");
	property p_even; pc_o[0] == 1'b0; endproperty
	a_even: assert property (p_even) else $error("odd program counter");
	property p_exc; exc_entry_i |=> flags_o[7]; endproperty
	a_exc: assert property (p_exc) else $error("mask not set");
	property p_rest; flag_restore_i && !exc_entry_i
		|=> {8'h00, flags_o} == ($past(flag_stack_word_i) >> 8); endproperty
	a_rest: assert property (p_rest) else $error("flag restore");
	property p_vec; vec_req_o && vec_ack_i
		|=> !vec_req_o && pc_o == ($past(vec_data_i) & 16'hFFFE); endproperty
	a_vec: assert property (p_vec) else $error("vector load");
	property p_step; pc_step_i && !pc_load_i && !vec_req_o
		|=> pc_o == $past(pc_o) + 16'h0002; endproperty
	a_step: assert property (p_step) else $error("program counter step");
endmodule
bind cpu_register_and_flags cpu_register_and_flags_asserts chk_inst (.*);

// >>> test/vec_fetch_model.sv
// Vector word source on the decoder side of the register file
`timescale 1ns/10ps
module vec_fetch_model #(parameter int DELAY = 4, parameter logic [15:0] WORD = 16'h0101) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic req_i,
	output logic ack_o,
	output logic [15:0] data_o
);
	int cnt = 0;
	initial begin
		ack_o = 1'b0;
		data_o = 16'h5555;
	end
	// Odd word on purpose; a released bus toggles so no stale word looks valid
	always @(posedge clk_i) begin
		#1;
		cnt = (rst_b_i && req_i) ? cnt + 1 : 0;
		ack_o = (cnt > DELAY);
		data_o = (cnt > DELAY) ? WORD : ~data_o;
	end
endmodule

// >>> test/cpu_register_and_flags_bench.sv
// Self-checking bench for the register file and flags
`timescale 1ns/10ps
module cpu_register_and_flags_bench;
	// -------------------
	// Signals and design
	// -------------------
	logic clk_i = '0, rst_b_i = '0;
	logic [2:0] rd_a_sel_i = '0, rd_b_sel_i = '0, addr_sel_i = '0, wr_sel_i = '0, bit_num_i = '0;
	logic rd_a_high_i = '0, rd_b_high_i = '0, wr_en_i = '0, wr_word_i = '0, wr_high_i = '0;
	logic sp_inc_i = '0, sp_dec_i = '0, pc_load_i = '0, pc_step_i = '0, alu_word_i = '0;
	logic shift_carry_i = '0, bit_carry_i = '0, use_bit_carry_i = '0, use_shift_carry_i = '0;
	logic exc_entry_i = '0, flag_restore_i = '0, dec_sub_i = '0;
	logic [7:0] flag_upd_en_i = '0, flag_data_i = '0, dec_in_i = '0, bit_operand_i = '0;
	logic [15:0] wr_data_i = '0, pc_data_i = '0, alu_a_i = '0, alu_b_i = '0, alu_res_i = '0;
	logic [15:0] flag_stack_word_i = '0;
	cpu_regs_pkg::alu_op_type alu_op_i = cpu_regs_pkg::alu_none_type_op;
	cpu_regs_pkg::flag_cmd_type flag_cmd_i = cpu_regs_pkg::flag_idle;
	logic vec_req_o, vec_ack_i, irq_masked_o, dec_carry_o, bit_value_o;
	logic [3:0] branch_cond_o;
	logic [7:0] rd_a_byte_o, rd_b_byte_o, flags_o, dec_out_o;
	logic [15:0] rd_a_word_o, rd_b_word_o, addr_word_o, stack_ptr_o, pc_o, vec_data_i;
	logic [15:0] flag_push_word_o;
	int n_errors = 0;
	int n_compared = 0;
	always #2.5 clk_i = ~clk_i;
	cpu_register_and_flags cpu_register_and_flags_inst (.*);
	vec_fetch_model vec_fetch_model_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(vec_req_o),
		.ack_o(vec_ack_i), .data_o(vec_data_i));
	task automatic step();
		@(posedge clk_i);
		#1;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic stop_test();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic fcmd(input cpu_regs_pkg::flag_cmd_type c, input logic [7:0] d, f);
		flag_cmd_i = c;
		flag_data_i = d;
		step();
		chk("flags", {8'h00, f}, {8'h00, flags_o});
	endtask
	task automatic alu(input cpu_regs_pkg::alu_op_type op, input logic w,
		input logic [15:0] a, b, r, input logic [7:0] en, f);
		{alu_op_i, alu_word_i, alu_a_i, alu_b_i, alu_res_i, flag_upd_en_i} = {op, w, a, b, r, en};
		step();
		chk("alu", {8'h00, f}, {8'h00, flags_o});
	endtask
	// -------------------
	// Scenarios
	// -------------------
	task automatic t_vector();
		for (int i = 0; i < 40 && vec_req_o !== 1'b0; i++) step();
		chk("vec_done", 16'h0000, {15'h0000, vec_req_o});
		if (vec_req_o !== 1'b0) stop_test();
		chk("pc_vec", 16'h0100, pc_o);
	endtask
	task automatic t_regs();
		{wr_en_i, wr_word_i, wr_sel_i, wr_data_i} = {2'b11, 3'h2, 16'h1234};
		step();
		{wr_word_i, wr_high_i, wr_data_i} = {2'b01, 16'h00AB};
		step();
		{wr_en_i, rd_a_sel_i, rd_a_high_i, rd_b_sel_i, addr_sel_i} = {1'b0, 3'h2, 1'b1, 3'h2, 3'h2};
		step();
		chk("word", 16'hAB34, rd_a_word_o);
		chk("high", 16'h00AB, {8'h00, rd_a_byte_o});
		chk("low", 16'h0034, {8'h00, rd_b_byte_o});
		chk("addr", 16'hAB34, addr_word_o);
	endtask
	task automatic t_sp();
		{wr_en_i, wr_word_i, wr_sel_i, wr_data_i, sp_dec_i} = {2'b11, 3'h7, 16'h0100, 1'b1};
		step();
		chk("sp_wr", 16'h0100, stack_ptr_o);
		wr_en_i = 1'b0;
		repeat (2) step();
		{sp_dec_i, sp_inc_i} = 2'b01;
		step();
		sp_inc_i = 1'b0;
		chk("sp", 16'h00FE, stack_ptr_o);
	endtask
	task automatic t_pc();
		{pc_load_i, pc_data_i} = {1'b1, 16'h1235};
		step();
		{pc_load_i, pc_step_i} = 2'b01;
		chk("pc_load", 16'h1234, pc_o);
		step();
		pc_step_i = 1'b0;
		chk("pc_step", 16'h1236, pc_o);
	endtask
	task automatic t_flags();
		fcmd(cpu_regs_pkg::flag_load, 8'h50, 8'h50);
		fcmd(cpu_regs_pkg::flag_or, 8'h0F, 8'h5F);
		fcmd(cpu_regs_pkg::flag_and, 8'hF3, 8'h53);
		fcmd(cpu_regs_pkg::flag_xor, 8'hFF, 8'hAC);
		chk("push", 16'hACAC, flag_push_word_o);
		chk("cond", 16'h000C, {12'h000, branch_cond_o});
		{flag_restore_i, flag_stack_word_i} = {1'b1, 16'h5AC3};
		fcmd(cpu_regs_pkg::flag_load, 8'h00, 8'h5A);
		{flag_restore_i, flag_cmd_i, exc_entry_i} = {1'b0, cpu_regs_pkg::flag_idle, 1'b1};
		step();
		exc_entry_i = 1'b0;
		chk("exc", 16'h00DA, {8'h00, flags_o});
	endtask
	task automatic t_alu();
		fcmd(cpu_regs_pkg::flag_load, 8'h00, 8'h00);
		flag_cmd_i = cpu_regs_pkg::flag_idle;
		alu(cpu_regs_pkg::alu_add, 0, 16'h000F, 16'h0001, 16'h0010, 8'h2F, 8'h20);
		alu(cpu_regs_pkg::alu_sub, 0, 16'h0010, 16'h0011, 16'h00FF, 8'h2F, 8'h29);
		alu(cpu_regs_pkg::alu_add, 1, 16'h0F00, 16'h0100, 16'h1000, 8'h2F, 8'h20);
		alu(cpu_regs_pkg::alu_add, 0, 16'h0080, 16'h0080, 16'h0000, 8'h2F, 8'h07);
		alu(cpu_regs_pkg::alu_addc, 0, 16'h0007, 16'h0008, 16'h0010, 8'h2F, 8'h20);
		alu(cpu_regs_pkg::alu_cmp, 0, 16'h0001, 16'h0001, 16'h0000, 8'h2F, 8'h04);
		alu(cpu_regs_pkg::alu_subc, 0, 16'h0010, 16'h0001, 16'h000F, 8'h2F, 8'h20);
		alu(cpu_regs_pkg::alu_neg, 0, 16'h0000, 16'h0001, 16'h00FF, 8'h2F, 8'h29);
		alu(cpu_regs_pkg::alu_sub, 1, 16'h1000, 16'h0001, 16'h0FFF, 8'h2F, 8'h20);
		alu(cpu_regs_pkg::alu_add, 0, 16'h0080, 16'h0080, 16'h0000, 8'h00, 8'h20);
		{use_shift_carry_i, shift_carry_i} = 2'b11;
		alu(cpu_regs_pkg::alu_logic, 0, 16'h0000, 16'h0000, 16'h0001, 8'h01, 8'h21);
		{use_shift_carry_i, use_bit_carry_i} = 2'b01;
		alu(cpu_regs_pkg::alu_logic, 0, 16'h0000, 16'h0000, 16'h0001, 8'h01, 8'h20);
		{use_bit_carry_i, flag_upd_en_i} = '0;
	endtask
	task automatic t_dec();
		dec_in_i = 8'h12;
		step();
		chk("dec_h", 16'h0018, {8'h00, dec_out_o});
		fcmd(cpu_regs_pkg::flag_load, 8'h00, 8'h00);
		{flag_cmd_i, dec_in_i} = {cpu_regs_pkg::flag_idle, 8'h9A};
		step();
		chk("dec", 16'h0100, {7'h00, dec_carry_o, dec_out_o});
		fcmd(cpu_regs_pkg::flag_load, 8'h20, 8'h20);
		{flag_cmd_i, dec_sub_i, dec_in_i} = {cpu_regs_pkg::flag_idle, 1'b1, 8'h1B};
		step();
		dec_sub_i = 1'b0;
		chk("dec_sub", 16'h0015, {7'h00, dec_carry_o, dec_out_o});
	endtask
	task automatic t_bit();
		bit_operand_i = 8'h5A;
		for (int n = 0; n < 8; n++) begin
			bit_num_i = n[2:0];
			step();
			chk("bit", ({8'h00, 8'h5A} >> n) & 16'h0001, {15'h0000, bit_value_o});
		end
	endtask
	initial begin
		repeat (6) @(posedge clk_i);
		chk("flags_rst", 16'h0080, {8'h00, flags_o});
		#1;
		rst_b_i = 1'b1;
		repeat (3) step();
		t_vector();
		t_regs();
		t_sp();
		t_pc();
		t_flags();
		t_alu();
		t_dec();
		t_bit();
		stop_test();
	end
endmodule
